// ===== flash_erase_regs.svh
// Purpose: Opcodes, status bit positions, reset values and timing counts of the erase link
// Assumes: Included by its bare name from both ends
// Notes: Definitions only
`ifndef FLASH_ERASE_REGS_SVH
`define FLASH_ERASE_REGS_SVH

`define OP_BLOCK_ERASE_4K 8'h20
`define OP_BLOCK_ERASE_32K 8'h52
`define OP_BLOCK_ERASE_64K 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_WRITE_ENABLE 8'h06
`define OP_READ_STATUS 8'h05

`define STAT_BUSY_BIT 0
`define STAT_LATCH_BIT 1
`define STAT_ERROR_BIT 5

`define SECTOR_PROT_RESET 32'hFFFF_FFFF
`define SECTOR_LSB 16
`define SECTOR_MSB 20
`define FULL_FRAME_BYTES 3'h4

`define CLK_SYS_MHZ 125
`define BLOCK_ERASE_TIME_US 1000
`define WHOLE_ARRAY_ERASE_TIME_US 20000
`define HOST_LEAD_CYCLES 3'h4
`define HOST_GAP_CYCLES 5'h10

`endif

// ===== flash_erase_pkg.sv
// Purpose: Types shared by both ends of the erase link
// Assumes: Nothing
// Notes: Constants live in flash_erase_regs.svh
package flash_erase_pkg;

    typedef enum logic [1:0] {
        ERASE_4K = 2'b00,
        ERASE_32K = 2'b01,
        ERASE_64K = 2'b10,
        ERASE_CHIP = 2'b11
    } erase_size_e;

    typedef enum logic {
        ENG_IDLE = 1'b0,
        ENG_ERASE = 1'b1
    } engine_state_e;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_LEAD = 2'b01,
        HOST_SHIFT = 2'b10,
        HOST_GAP = 2'b11
    } host_state_e;

endpackage : flash_erase_pkg

// ===== flash_link_if.sv
// Purpose: Serial link between host controller and flash device
// Assumes: Mode 0, clock idles low
// Notes: The data-out line floats high when the device does not drive it
interface flash_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    assign miso_line = miso_oe ? miso : 1'b1;

    modport device (
        input cs_n,
        input sck,
        input mosi,
        output miso,
        output miso_oe
    );

    modport host (
        output cs_n,
        output sck,
        output mosi,
        input miso_line
    );
endinterface : flash_link_if

// ===== flash_erase_device.sv
// Purpose: Command front end of a serial flash for block erase, chip erase and write enable
// Assumes: Link in mode 0; serial clock still while chip select is high
// Notes: The array itself is outside; this block issues erase requests and timing
// Operation
// R1 - 20h, 52h, D8h pick 4K, 32K, 64K erase
// R2 - Erase sets every bit of region to one
// R3 - Block erase needs write latch set first
// R4 - Host sends opcode then three address bytes
// R5 - Release after valid block erase starts timed erase
// R6 - Address bits below block size are ignored
// R7 - Block erase needs full address, byte-aligned release
// R8 - Protected sector skips block erase
// R9 - Aborted block erase clears write latch
// R10 - Status read reports busy while erasing
// R11 - Successful erase clears write latch before finishing
// R12 - Failed byte verify sets error flag
// R13 - 60h or C7h chip erase, no address
// R14 - Chip erase needs write latch set first
// R15 - Release after valid chip erase erases whole array
// R16 - Chip erase needs full opcode, byte-aligned release
// R17 - Any protected sector blocks chip erase, clears latch
// R18 - Write commands need write latch already set
// R19 - 06h sets write latch at release
// R20 - Incomplete write enable leaves latch unchanged
// R21 - All sectors protected after reset
// R22 - Protection check covers every sector of block
// R23 - Busy from accepted erase until timer ends
`include "flash_erase_regs.svh"

module flash_erase_device
    import flash_erase_pkg::*;
#(
    parameter int unsigned BLOCK_ERASE_CYCLES = `BLOCK_ERASE_TIME_US * `CLK_SYS_MHZ,
    parameter int unsigned CHIP_ERASE_CYCLES = `WHOLE_ARRAY_ERASE_TIME_US * `CLK_SYS_MHZ
) (
    input wire logic clk_sys,
    input wire logic nrst,
    flash_link_if.device link,
    input wire logic prot_write,
    input wire logic [4:0] prot_index,
    input wire logic prot_value,
    output logic [31:0] prot_bits,
    output logic erase_start,
    output logic [23:0] erase_base,
    output erase_size_e erase_size,
    input wire logic erase_fail,
    output logic busy,
    output logic write_latch_flag,
    output logic erase_program_error_flag
);

    function automatic logic [23:0] block_base(input logic [23:0] addr, input erase_size_e size);
        logic [23:0] base;
        base = addr;
        unique case (size)
            ERASE_4K: base[11:0] = 12'h000;
            ERASE_32K: base[14:0] = 15'h0000;
            ERASE_64K: base[15:0] = 16'h0000;
            ERASE_CHIP: base = 24'h00_0000;
        endcase
        return base;
    endfunction : block_base

    // An aligned block never spans more than one 64K sector, so its base names the only sector
    function automatic logic block_protected(input logic [31:0] prot, input logic [23:0] addr,
                                             input erase_size_e size);
        logic [23:0] base;
        base = block_base(addr, size);
        return prot[base[`SECTOR_MSB:`SECTOR_LSB]]; // [R22] [R8]
    endfunction : block_protected

    // Link domain: frame capture on the serial clock
    logic frame_idle;
    logic fresh_reg;
    logic frame_tog_reg;
    logic [2:0] bit_cnt_reg;
    logic [2:0] byte_cnt_reg;
    logic [31:0] shift_reg;
    logic [7:0] op_reg;
    logic [2:0] stat_meta_reg;
    logic [2:0] stat_sync_reg;
    logic [7:0] stat_byte;
    logic rd_active;
    logic miso_reg;
    logic miso_oe_reg;

    assign frame_idle = link.cs_n | ~nrst;

    // Marks the first edge of a frame, since the counters cannot be cleared without an edge
    always_ff @(posedge link.sck or posedge frame_idle) begin
        if (frame_idle) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    always_ff @(posedge link.sck or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
            shift_reg <= 32'h0000_0000;
            frame_tog_reg <= 1'b0;
        end else if (fresh_reg) begin
            // A frame with no clock edge leaves the counters stale; the toggle marks real ones
            frame_tog_reg <= ~frame_tog_reg;
            bit_cnt_reg <= 3'h1;
            byte_cnt_reg <= 3'h0;
            shift_reg <= {31'h0000_0000, link.mosi};
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            // Bytes past the address are counted out and dropped
            if (byte_cnt_reg != `FULL_FRAME_BYTES) begin
                shift_reg <= {shift_reg[30:0], link.mosi}; // [R4]
                if (bit_cnt_reg == 3'h7) begin
                    byte_cnt_reg <= byte_cnt_reg + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge link.sck or negedge nrst) begin
        if (!nrst) begin
            op_reg <= 8'h00;
        end else if (!fresh_reg && bit_cnt_reg == 3'h7 && byte_cnt_reg == 3'h0) begin
            op_reg <= {shift_reg[6:0], link.mosi};
        end
    end

    always_ff @(posedge link.sck or negedge nrst) begin
        if (!nrst) begin
            stat_meta_reg <= 3'h0;
            stat_sync_reg <= 3'h0;
        end else begin
            stat_meta_reg <= {erase_program_error_flag, write_latch_flag, busy};
            stat_sync_reg <= stat_meta_reg;
        end
    end

    always_comb begin
        stat_byte = 8'h00;
        stat_byte[`STAT_BUSY_BIT] = stat_sync_reg[0]; // [R10]
        stat_byte[`STAT_LATCH_BIT] = stat_sync_reg[1];
        stat_byte[`STAT_ERROR_BIT] = stat_sync_reg[2];
    end

    assign rd_active = !fresh_reg && byte_cnt_reg != 3'h0 && op_reg == `OP_READ_STATUS;

    always_ff @(negedge link.sck or posedge frame_idle) begin
        if (frame_idle) begin
            miso_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else if (rd_active) begin
            miso_reg <= stat_byte[3'h7 - bit_cnt_reg]; // [R10]
            miso_oe_reg <= 1'b1;
        end
    end

    assign link.miso = miso_reg;
    assign link.miso_oe = miso_oe_reg;

    // System domain: frame end, decode and erase engine
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic release_evt;
    logic tog_seen_reg;
    logic have_op;
    logic have_addr;
    logic aligned;
    logic is_block;
    logic is_chip;
    erase_size_e size_sel;
    logic start;
    logic latch_set;
    logic latch_clr;
    engine_state_e state_reg;
    logic [31:0] timer_reg;
    logic [31:0] prot_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
            tog_seen_reg <= 1'b0;
        end else begin
            cs_meta_reg <= link.cs_n;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
            if (release_evt) begin
                tog_seen_reg <= frame_tog_reg;
            end
        end
    end

    assign release_evt = cs_sync_reg & ~cs_prev_reg;

    // Frame words are static once chip select is high, so they are read directly at release
    assign have_op = byte_cnt_reg != 3'h0;
    assign have_addr = byte_cnt_reg == `FULL_FRAME_BYTES;
    assign aligned = bit_cnt_reg == 3'h0;

    always_comb begin
        is_block = 1'b1;
        size_sel = ERASE_CHIP;
        unique case (op_reg)
            `OP_BLOCK_ERASE_4K: size_sel = ERASE_4K; // [R1]
            `OP_BLOCK_ERASE_32K: size_sel = ERASE_32K; // [R1]
            `OP_BLOCK_ERASE_64K: size_sel = ERASE_64K; // [R1]
            default: is_block = 1'b0;
        endcase
    end

    assign is_chip = op_reg == `OP_CHIP_ERASE_A || op_reg == `OP_CHIP_ERASE_B; // [R13]

    always_comb begin
        start = 1'b0;
        latch_set = 1'b0;
        latch_clr = 1'b0;
        if (release_evt && have_op && frame_tog_reg != tog_seen_reg && state_reg == ENG_IDLE) begin
            if (op_reg == `OP_WRITE_ENABLE) begin
                latch_set = aligned; // [R19] [R20]
            end else if (is_block && write_latch_flag) begin // [R3] [R18]
                if (!(have_addr && aligned)) begin
                    latch_clr = 1'b1; // [R7] [R9]
                end else if (block_protected(prot_reg, shift_reg[23:0], size_sel)) begin
                    latch_clr = 1'b1; // [R8] [R9]
                end else begin
                    start = 1'b1; // [R5]
                end
            end else if (is_chip && write_latch_flag && aligned) begin // [R14] [R16] [R18]
                if (|prot_reg) begin
                    latch_clr = 1'b1; // [R17]
                end else begin
                    start = 1'b1; // [R15]
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            write_latch_flag <= 1'b0;
        end else if (latch_set) begin
            write_latch_flag <= 1'b1; // [R19]
        end else if (latch_clr || start) begin
            write_latch_flag <= 1'b0; // [R11]
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ENG_IDLE;
            timer_reg <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                ENG_IDLE: begin
                    if (start) begin
                        state_reg <= ENG_ERASE; // [R23]
                        timer_reg <= is_chip ? CHIP_ERASE_CYCLES - 1 : BLOCK_ERASE_CYCLES - 1;
                    end
                end
                ENG_ERASE: begin
                    if (timer_reg == 32'h0000_0000) begin
                        state_reg <= ENG_IDLE; // [R23]
                    end else begin
                        timer_reg <= timer_reg - 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    assign busy = state_reg == ENG_ERASE;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            erase_start <= 1'b0;
            erase_base <= 24'h00_0000;
            erase_size <= ERASE_4K;
        end else begin
            erase_start <= start; // [R2]
            if (start) begin
                erase_base <= block_base(shift_reg[23:0], is_chip ? ERASE_CHIP : size_sel); // [R6]
                erase_size <= is_chip ? ERASE_CHIP : size_sel;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            erase_program_error_flag <= 1'b0;
        end else if (busy && erase_fail) begin
            erase_program_error_flag <= 1'b1; // [R12]
        end else if (start) begin
            erase_program_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prot_reg <= `SECTOR_PROT_RESET; // [R21]
        end else if (prot_write) begin
            prot_reg[prot_index] <= prot_value;
        end
    end

    assign prot_bits = prot_reg;

endmodule : flash_erase_device

// ===== flash_erase_host.sv
// Purpose: Host controller that frames erase, write-enable and status commands on the link
// Assumes: Serial clock is clk_sys divided by eight, mode 0
// Notes: cmd_bits lets a caller cut a frame short or off a byte boundary
`include "flash_erase_regs.svh"

module flash_erase_host
    import flash_erase_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    flash_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_op,
    input wire logic [23:0] cmd_addr,
    input wire logic [5:0] cmd_bits,
    output logic rsp_valid,
    output logic [7:0] rsp_byte
);

    host_state_e state_reg;
    logic [2:0] phase_reg;
    logic [4:0] wait_reg;
    logic [5:0] bits_left_reg;
    logic [31:0] tx_reg;
    logic cs_n_reg;
    logic sck_reg;
    logic miso_meta_reg;
    logic miso_sync_reg;

    assign cmd_ready = state_reg == HOST_IDLE;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            miso_meta_reg <= 1'b1;
            miso_sync_reg <= 1'b1;
        end else begin
            miso_meta_reg <= link.miso_line;
            miso_sync_reg <= miso_meta_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= HOST_IDLE;
            phase_reg <= 3'h0;
            wait_reg <= 5'h00;
            bits_left_reg <= 6'h00;
            tx_reg <= 32'h0000_0000;
            cs_n_reg <= 1'b1;
            sck_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                HOST_IDLE: begin
                    if (cmd_valid) begin
                        // Opcode first, then address most significant byte first
                        tx_reg <= {cmd_op, cmd_addr}; // [R1] [R4] [R13] [R19]
                        bits_left_reg <= cmd_bits;
                        cs_n_reg <= 1'b0;
                        wait_reg <= 5'h00;
                        state_reg <= HOST_LEAD;
                    end
                end
                HOST_LEAD: begin
                    wait_reg <= wait_reg + 5'h01;
                    if (wait_reg[2:0] == `HOST_LEAD_CYCLES - 3'h1) begin
                        phase_reg <= 3'h0;
                        state_reg <= bits_left_reg == 6'h00 ? HOST_GAP : HOST_SHIFT;
                        wait_reg <= 5'h00;
                    end
                end
                HOST_SHIFT: begin
                    phase_reg <= phase_reg + 3'h1;
                    if (phase_reg == 3'h3) begin
                        sck_reg <= 1'b1;
                    end
                    if (phase_reg == 3'h7) begin
                        sck_reg <= 1'b0;
                        tx_reg <= {tx_reg[30:0], 1'b0};
                        bits_left_reg <= bits_left_reg - 6'h01;
                        if (bits_left_reg == 6'h01) begin
                            state_reg <= HOST_GAP; // [R7] [R16]
                        end
                    end
                end
                HOST_GAP: begin
                    cs_n_reg <= 1'b1;
                    wait_reg <= wait_reg + 5'h01;
                    // Gap outlasts the device's chip-select synchroniser
                    if (wait_reg == `HOST_GAP_CYCLES - 5'h01) begin
                        state_reg <= HOST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rsp_byte <= 8'h00;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= state_reg == HOST_GAP && wait_reg == `HOST_GAP_CYCLES - 5'h01;
            if (state_reg == HOST_SHIFT && phase_reg == 3'h7) begin
                rsp_byte <= {rsp_byte[6:0], miso_sync_reg}; // [R10]
            end
        end
    end

    assign link.cs_n = cs_n_reg;
    assign link.sck = sck_reg;
    assign link.mosi = tx_reg[31];

endmodule : flash_erase_host

// ===== flash_erase_sva.sv
// Purpose: Concurrent checks on the erase link and the device flag outputs
// Assumes: Instantiated beside the link interface, erase lengths passed down
// Notes: Busy length is counted in helper logic, far beyond what a repetition can hold
module flash_erase_sva
    import flash_erase_pkg::*;
#(
    parameter int unsigned BLOCK_ERASE_CYCLES = 20,
    parameter int unsigned CHIP_ERASE_CYCLES = 40
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic miso_oe,
    input wire logic miso_line,
    input wire logic [31:0] prot_bits,
    input wire logic erase_start,
    input wire logic [23:0] erase_base,
    input wire erase_size_e erase_size,
    input wire logic erase_fail,
    input wire logic busy,
    input wire logic write_latch_flag,
    input wire logic erase_program_error_flag
);
    logic [31:0] run_len;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            run_len <= 32'h0000_0000;
        end else if (erase_start) begin
            run_len <= 32'h0000_0001;
        end else if (busy) begin
            run_len <= run_len + 32'h0000_0001;
        end
    end

    AST_SCK_STILL: assert property (cs_n && $past(cs_n) |-> !sck)
        else $error("serial clock moved outside a frame");
    AST_OE_IDLE: assert property (cs_n |-> !miso_oe && miso_line)
        else $error("data out driven while deselected");
    AST_START_BUSY: assert property (erase_start |-> busy && !write_latch_flag)
        else $error("erase start without busy or with latch set");
    AST_BUSY_CAUSE: assert property ($rose(busy) |-> erase_start)
        else $error("busy rose without erase start");
    AST_START_LATCH: assert property (erase_start |-> $past(write_latch_flag))
        else $error("erase started without write latch");
    AST_START_RELEASE: assert property (erase_start |-> cs_n && $past(cs_n, 2))
        else $error("erase started before chip select release");
    AST_BASE_ALIGNED: assert property (erase_start |-> erase_size == ERASE_CHIP
        || (erase_size == ERASE_4K && erase_base[11:0] == 12'h000)
        || (erase_size == ERASE_32K && erase_base[14:0] == 15'h0000)
        || (erase_size == ERASE_64K && erase_base[15:0] == 16'h0000))
        else $error("erase base not aligned to block size");
    AST_PROT_CLEAR: assert property (erase_start |-> (erase_size == ERASE_CHIP)
        ? (prot_bits == 32'h0000_0000) : !prot_bits[erase_base[20:16]])
        else $error("erase started on protected sector");
    AST_BUSY_LENGTH: assert property ($fell(busy) |-> run_len
        == ((erase_size == ERASE_CHIP) ? CHIP_ERASE_CYCLES : BLOCK_ERASE_CYCLES))
        else $error("erase busy time wrong");
    AST_LATCH_BUSY: assert property (busy |-> !write_latch_flag)
        else $error("write latch set while erasing");
    AST_FAIL_FLAG: assert property (busy && erase_fail |=> erase_program_error_flag)
        else $error("erase failure not flagged");

    COV_BLOCK: cover property (erase_start && erase_size != ERASE_CHIP);
    COV_CHIP: cover property (erase_start && erase_size == ERASE_CHIP);
    COV_ERROR: cover property ($rose(erase_program_error_flag));
endmodule : flash_erase_sva

// ===== serial_flash_erase_and_write_enable_test.sv
// Purpose: Self-checking bench joining host and device over the link
// Assumes: Erase lengths shortened but long enough for a status read in busy
// Notes: Driver queues expected status bytes and erases, a monitor compares
`include "flash_erase_regs.svh"

module serial_flash_erase_and_write_enable_test
    import flash_erase_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned BLK = 400;
    localparam int unsigned CHP = 800;
    logic clk_sys, nrst, cmd_valid, cmd_ready, rsp_valid, prot_write, prot_value;
    logic erase_fail, erase_start, busy, write_latch_flag, erase_program_error_flag;
    logic [7:0] cmd_op, rsp_byte;
    logic [23:0] cmd_addr, erase_base, a;
    logic [5:0] cmd_bits;
    logic [4:0] prot_index, s;
    logic [31:0] prot_bits, r;
    logic [25:0] e;
    logic w_m, e_m;
    erase_size_e erase_size;
    int failures, total_checks, cycles, seed;
    logic [7:0] st_q[$];
    logic [25:0] er_q[$];
    logic [7:0] ops[3] = '{`OP_BLOCK_ERASE_4K, `OP_BLOCK_ERASE_32K, `OP_BLOCK_ERASE_64K};
    logic [23:0] msks[3] = '{24'hFF_F000, 24'hFF_8000, 24'hFF_0000};

    flash_link_if link ();
    flash_erase_device #(.BLOCK_ERASE_CYCLES(BLK), .CHIP_ERASE_CYCLES(CHP)) u_flash_erase_device (
        .clk_sys(clk_sys), .nrst(nrst), .link(link), .prot_write(prot_write),
        .prot_index(prot_index), .prot_value(prot_value), .prot_bits(prot_bits),
        .erase_start(erase_start), .erase_base(erase_base), .erase_size(erase_size),
        .erase_fail(erase_fail), .busy(busy), .write_latch_flag(write_latch_flag),
        .erase_program_error_flag(erase_program_error_flag));
    flash_erase_host u_flash_erase_host (.clk_sys(clk_sys), .nrst(nrst), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_bits(cmd_bits), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
    flash_erase_sva #(.BLOCK_ERASE_CYCLES(BLK), .CHIP_ERASE_CYCLES(CHP)) u_flash_erase_sva (
        .clk_sys(clk_sys), .nrst(nrst), .cs_n(link.cs_n), .sck(link.sck),
        .miso_oe(link.miso_oe), .miso_line(link.miso_line), .prot_bits(prot_bits),
        .erase_start(erase_start), .erase_base(erase_base), .erase_size(erase_size),
        .erase_fail(erase_fail), .busy(busy), .write_latch_flag(write_latch_flag),
        .erase_program_error_flag(erase_program_error_flag));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            complete_run();
        end
    end

    // Sampled on the falling edge so one-cycle pulses are settled
    always @(negedge clk_sys) begin
        if (rsp_valid === 1'b1 && st_q.size() > 0) begin
            check("status", 32'(rsp_byte), 32'(st_q.pop_front()));
        end
        if (erase_start === 1'b1) begin
            if (er_q.size() == 0) begin
                check("unexpected_erase", 32'h1, 32'h0);
            end else begin
                e = er_q.pop_front();
                check("erase_size", 32'(erase_size), 32'(e[25:24]));
                if (e[25:24] != ERASE_CHIP) begin
                    check("erase_base", 32'(erase_base), 32'(e[23:0]));
                end
            end
        end
    end

    // Request held from one edge to the taking edge, then released
    task automatic send(input logic [7:0] op, input logic [23:0] ad, input int bits);
        do @(negedge clk_sys); while (cmd_ready !== 1'b1);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= ad;
        cmd_bits <= bits[5:0];
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        do @(negedge clk_sys); while (rsp_valid !== 1'b1);
        // Return past the answer, so a note queued next is never matched against it
        @(posedge clk_sys);
    endtask : send

    task automatic status(input logic b);
        st_q.push_back({2'b00, e_m, 3'b000, w_m, b});
        send(`OP_READ_STATUS, 24'h00_0000, 16);
    endtask : status

    task automatic wen(input int bits);
        send(`OP_WRITE_ENABLE, 24'h00_0000, bits);
        if (bits % 8 == 0) w_m = 1'b1;
    endtask : wen

    task automatic erase(input logic [7:0] op, input logic [23:0] ad, input int bits,
                         input logic ok, input logic [1:0] sz, input logic [23:0] msk);
        if (ok) begin
            er_q.push_back({sz, ad & msk});
            e_m = 1'b0;
        end
        send(op, ad, bits);
        w_m = 1'b0;
    endtask : erase

    task automatic prot(input logic [4:0] idx, input logic val);
        @(posedge clk_sys);
        prot_write <= 1'b1;
        prot_index <= idx;
        prot_value <= val;
        @(posedge clk_sys);
        prot_write <= 1'b0;
    endtask : prot

    initial begin
        seed = 93;
        {failures, total_checks, cycles} = '0;
        {nrst, cmd_valid, prot_write, prot_value, erase_fail, w_m, e_m} = '0;
        {cmd_op, cmd_addr, cmd_bits, prot_index} = '0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        check("prot_bits", prot_bits, 32'hFFFF_FFFF);
        check("flags", 32'({busy, write_latch_flag, erase_program_error_flag}), 32'h0);
        r = $random(seed);
        s = r[20:16];
        prot(s, 1'b0);
        a = {3'b000, s, r[15:0]};
        send(`OP_BLOCK_ERASE_4K, a, 32);
        status(1'b0);
        wen(7);
        wen(12);
        w_m = 1'b0;
        status(1'b0);
        wen(16);
        status(1'b0);
        erase(`OP_BLOCK_ERASE_64K, {3'b000, s + 5'h01, r[15:0]}, 32, 1'b0, 2'b10, 24'h0);
        status(1'b0);
        for (int i = 24; i <= 35; i += 11) begin
            wen(8);
            erase(`OP_BLOCK_ERASE_32K, a, i, 1'b0, 2'b01, 24'h0);
            status(1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            r = $random(seed);
            wen(8);
            erase(ops[i], {3'b000, s, r[15:0]}, (i == 2) ? 40 : 32, 1'b1, 2'(i), msks[i]);
            status(1'b1);
            send(`OP_WRITE_ENABLE, 24'h00_0000, 8);
            erase_fail <= (i == 1);
            do @(negedge clk_sys); while (busy !== 1'b0);
            @(posedge clk_sys);
            erase_fail <= 1'b0;
            e_m = (i == 1);
            status(1'b0);
        end
        wen(8);
        erase(`OP_CHIP_ERASE_A, 24'h00_0000, 8, 1'b0, 2'b11, 24'h0);
        status(1'b0);
        for (int k = 0; k < 32; k++) prot(5'(k), 1'b0);
        wen(8);
        send(`OP_CHIP_ERASE_B, 24'h00_0000, 12);
        status(1'b0);
        for (int i = 0; i < 2; i++) begin
            wen(8);
            erase(i ? `OP_CHIP_ERASE_B : `OP_CHIP_ERASE_A, r[23:0], 16, 1'b1, 2'b11, 24'h0);
            status(1'b1);
            do @(negedge clk_sys); while (busy !== 1'b0);
            status(1'b0);
        end
        check("pending", 32'(st_q.size() + er_q.size()), 32'h0);
        complete_run();
    end
endmodule : serial_flash_erase_and_write_enable_test
